//--- tb.sv
// self-checking bench for the issue front end and interrupt map
`timescale 1ns/1ps
module tb;
    logic          sys_clk = 1'h0;
    logic          reset_n = 1'h0;
    logic          fetch_valid = 1'h0;
    logic [255:0]  fetch_data = 256'h0;
    logic [255:0]  p1, p2, p3;
    logic          fetch_ready, pkt_err, evt_trig_we = 1'h0;
    logic [7:0]    unit_vld, mem_be, wb_en = 8'h00;
    logic [1:0]    mem_req, mem_we, tick_ovf, i2c_int, spi_int;
    logic [31:0]   evt_trig_data = 32'h0, evt_stat_set = 32'h0, evt_stat_clr = 32'h0;
    logic [31:0]   trig_q, stat_q;
    logic [14:0]   src = 15'h0;
    logic [4:0]    evt = 5'h00;
    logic [10:0]   shared_en = 11'h000;
    logic [15:0]   cpu_int;
    logic [3:0]    tick_int;
    logic [2:0]    dma_evt_code;
    logic          dma_nmi, xmem_nmi, host_port_int, dma_fifo_int, dma_done_int;
    logic          dma_evt_vld, dma_evt_int_en, st_seen = 1'h0;
    logic [7:0]    q [$];
    int            n_errors = 0, check_count = 0, i, err_seen = 0;
    // rows: {expected lines, shared enables, sources, {vld, int_en, code}}
    localparam logic [46:0] ROWS [20] = '{
        {16'h0002, 11'h001, 15'h0001, 5'h00}, {16'h0002, 11'h002, 15'h0002, 5'h00},
        {16'h0000, 11'h002, 15'h0001, 5'h00}, {16'h0010, 11'h000, 15'h0004, 5'h00},
        {16'h0020, 11'h004, 15'h0008, 5'h00}, {16'h0020, 11'h040, 15'h0080, 5'h00},
        {16'h0000, 11'h004, 15'h0020, 5'h00}, {16'h0040, 11'h000, 15'h0100, 5'h00},
        {16'h0180, 11'h000, 15'h0600, 5'h00}, {16'h4000, 11'h080, 15'h0800, 5'h00},
        {16'h4000, 11'h400, 15'h4000, 5'h00}, {16'h0000, 11'h000, 15'h0000, 5'h13},
        {16'h8000, 11'h000, 15'h0000, 5'h1F}, {16'h0200, 11'h000, 15'h0000, 5'h1A},
        {16'h0400, 11'h000, 15'h0000, 5'h1B}, {16'h0800, 11'h000, 15'h0000, 5'h1C},
        {16'h1000, 11'h000, 15'h0000, 5'h1D}, {16'h2000, 11'h000, 15'h0000, 5'h1E},
        {16'h0000, 11'h000, 15'h0000, 5'h19}, {16'hC1F2, 11'h7FF, 15'h7FFF, 5'h1F}};
    // chain of two, singles, then a packet spanning both fetches
    localparam logic [7:0] SEQ [14] = '{8'h03, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h81,
        8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

    always #50 sys_clk = ~sys_clk;

    vim_core dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(1'h1),
        .fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_ready(fetch_ready),
        .unit_vld(unit_vld), .unit_ins(), .fp_addsub_cnt(), .pkt_err(pkt_err),
        .rd_limit_err(), .xpath_err(), .op_vld(), .op_a(), .op_b(), .wb_en(wb_en),
        .wb_addr(40'h0), .wb_data(256'h0), .mem_req(mem_req), .mem_we(mem_we),
        .mem_be(mem_be), .mem_addr(), .mem_wdata(), .evt_trig_we(evt_trig_we),
        .evt_trig_data(evt_trig_data), .evt_stat_set(evt_stat_set),
        .evt_stat_clr(evt_stat_clr), .dma_event_trigger_reg(trig_q),
        .dma_event_status_reg(stat_q), .dma_nmi(dma_nmi), .external_memory_if_nmi(xmem_nmi),
        .realtime_tick_timer_int(tick_int), .realtime_tick_timer_ovf(tick_ovf),
        .host_port_int(host_port_int),
        .dma_fifo_int(dma_fifo_int), .dma_done_int(dma_done_int),
        .dma_evt_vld(dma_evt_vld), .dma_evt_code(dma_evt_code),
        .dma_evt_int_en(dma_evt_int_en), .i2c_int(i2c_int), .spi_int(spi_int),
        .shared_en(shared_en), .cpu_int(cpu_int));

    vim_periph_model model (.sys_clk(sys_clk), .reset_n(reset_n), .src(src), .evt(evt),
        .dma_nmi(dma_nmi), .external_memory_if_nmi(xmem_nmi),
        .realtime_tick_timer_int(tick_int), .realtime_tick_timer_ovf(tick_ovf),
        .host_port_int(host_port_int), .dma_fifo_int(dma_fifo_int),
        .dma_done_int(dma_done_int), .i2c_int(i2c_int), .spi_int(spi_int),
        .dma_evt_vld(dma_evt_vld), .dma_evt_code(dma_evt_code),
        .dma_evt_int_en(dma_evt_int_en));

    function automatic logic [31:0] ins(input logic [2:0] u, input logic p,
                                        input logic [5:0] op);
        ins = 32'h0;
        ins[vim_pkg::OPC_LSB +: 6] = op;
        ins[vim_pkg::UNIT_LSB +: 3] = u;
        ins[vim_pkg::PBIT_POS] = p;
    endfunction

    task finish_test;
        if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // holds the packet until an edge that sees fetch_ready high
    task send(input logic [255:0] d);
        int k;
        fetch_data <= d;
        fetch_valid <= 1'h1;
        for (k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            if (fetch_ready === 1'h1) break;
        end
        if (k == 40) begin
            n_errors++;
            finish_test();
        end
        @(posedge sys_clk);
    endtask

    initial begin
        for (i = 0; i < 8; i++) begin
            p1[32*i +: 32] = ins(3'(i), (i == 0) || (i == 7), 6'h00);
            p2[32*i +: 32] = ins(3'(i), 1'h0, (i == 3) ? vim_pkg::OP_STB : 6'h00);
            p3[32*i +: 32] = ins(3'(i), 1'h1, 6'h00);
        end
        repeat (12) @(posedge sys_clk);
        chk(32'(cpu_int), 32'h1);
        chk(32'(fetch_ready), 32'h1);
        chk(32'(unit_vld), 32'h0);
        reset_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        for (i = 0; i < 20; i++) begin
            src <= ROWS[i][19:5];
            evt <= ROWS[i][4:0];
            shared_en <= ROWS[i][30:20];
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(32'(cpu_int), 32'(ROWS[i][46:31]));
            @(posedge sys_clk);
        end
        // register 0 of side one is the store address; unwritten it reads unknown
        wb_en <= 8'h01;
        @(posedge sys_clk);
        wb_en <= 8'h00;
        fork
            begin
                send(p1);
                send(p2);
                fetch_valid <= 1'h0;
            end
            repeat (30) begin
                @(negedge sys_clk);
                if (unit_vld !== 8'h00) q.push_back(unit_vld);
                if (mem_req[0] === 1'h1 && mem_we[0] === 1'h1 && mem_be[3:0] === 4'h1)
                    st_seen = 1'h1;
                if (pkt_err === 1'h1) err_seen++;
            end
        join
        chk(q.size(), 14);
        if (q.size() == 14) for (i = 0; i < 14; i++) chk(32'(q[i]), 32'(SEQ[i]));
        chk(err_seen, 0);
        chk(32'(st_seen), 32'h1);
        // a chain of eight words with every p bit set is cut at eight and flagged
        @(posedge sys_clk);
        send(p3);
        fetch_valid <= 1'h0;
        repeat (3) begin
            @(negedge sys_clk);
            if (pkt_err === 1'h1 && unit_vld === 8'hFF) err_seen++;
        end
        chk(err_seen, 1);
        @(posedge sys_clk);
        evt_trig_we <= 1'h1;
        evt_trig_data <= 32'hA5A50F0F;
        evt_stat_set <= 32'h000000F0;
        @(posedge sys_clk);
        evt_trig_we <= 1'h0;
        evt_stat_set <= 32'h00000010;
        evt_stat_clr <= 32'h00000030;
        @(negedge sys_clk);
        chk(trig_q, 32'hA5A50F0F);
        chk(stat_q, 32'h000000F0);
        @(posedge sys_clk);
        evt_stat_set <= 32'h0;
        evt_stat_clr <= 32'h0;
        @(negedge sys_clk);
        chk(stat_q, 32'h000000D0);
        // mid-run reset with every source still active
        @(posedge sys_clk);
        reset_n <= 1'h0;
        @(negedge sys_clk);
        chk(32'(cpu_int), 32'h1);
        chk(stat_q, 32'h0);
        @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(32'(cpu_int), 32'hC1F2);
        finish_test();
    end
endmodule

//--- vim_core.sv
// fetch window, execute packet dispatch, operand read and interrupt map
`timescale 1ns/1ps
module vim_core (
    // clock and reset
    input  wire logic          sys_clk,
    input  wire logic          reset_n,
    input  wire logic          ce,
    // fetch packets
    input  wire logic          fetch_valid,
    input  wire logic [255:0]  fetch_data,
    output logic               fetch_ready,
    // dispatched instructions, unit order l1 s1 m1 d1 l2 s2 m2 d2
    output logic [7:0]         unit_vld,
    output logic [255:0]       unit_ins,
    output logic [3:0]         fp_addsub_cnt,
    output logic               pkt_err,
    output logic               rd_limit_err,
    output logic               xpath_err,
    // operands, one stage after dispatch
    output logic [7:0]         op_vld,
    output logic [255:0]       op_a,
    output logic [255:0]       op_b,
    // writeback per unit
    input  wire logic [7:0]    wb_en,
    input  wire logic [39:0]   wb_addr,
    input  wire logic [255:0]  wb_data,
    // memory side of the load-store units, index 0 = side 1
    output logic [1:0]         mem_req,
    output logic [1:0]         mem_we,
    output logic [7:0]         mem_be,
    output logic [63:0]        mem_addr,
    output logic [63:0]        mem_wdata,
    // dma event registers
    input  wire logic          evt_trig_we,
    input  wire logic [31:0]   evt_trig_data,
    input  wire logic [31:0]   evt_stat_set,
    input  wire logic [31:0]   evt_stat_clr,
    output logic [31:0]        dma_event_trigger_reg,
    output logic [31:0]        dma_event_status_reg,
    // interrupt sources
    input  wire logic          dma_nmi,
    input  wire logic          external_memory_if_nmi,
    input  wire logic [3:0]    realtime_tick_timer_int,
    input  wire logic [1:0]    realtime_tick_timer_ovf,
    input  wire logic          host_port_int,
    input  wire logic          dma_fifo_int,
    input  wire logic          dma_done_int,
    input  wire logic          dma_evt_vld,
    input  wire logic [2:0]    dma_evt_code,
    input  wire logic          dma_evt_int_en,
    input  wire logic [1:0]    i2c_int,
    input  wire logic [1:0]    spi_int,
    input  wire logic [10:0]   shared_en,
    output logic [15:0]        cpu_int
);
    logic       rst_s1_r;
    logic       rst_n_r;
    logic [31:0] win_r [16];
    logic [31:0] win_nxt [16];
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // find packet end: first clear p bit in the first eight words
    logic       found;
    logic [3:0] end_len;
    always_comb begin
        found   = 1'b0;
        end_len = 4'h8;
        for (int i = vim_pkg::FP_WORDS - 1; i >= 0; i--) begin
            if (i < int'(cnt_r) && !win_r[i][vim_pkg::PBIT_POS]) begin
                found   = 1'b1;
                end_len = 4'(i + 1);
            end
        end
    end

    // overlong chain is cut at eight and flagged
    wire        fire  = found || (cnt_r >= 5'h08);
    wire        overl = fire && !found;
    wire [4:0]  take  = fire ? {1'b0, end_len} : 5'h00;
    wire [4:0]  rem   = cnt_r - take;
    // accept only when the new packet fits behind the leftover words
    wire        accept = fetch_valid && (rem <= 5'h08);
    assign fetch_ready = accept ? 1'b1 : (rem <= 5'h08);
    assign cnt_nxt     = accept ? rem + 5'h08 : rem;

    // shift out the issued packet, append the fetch packet behind the tail
    always_comb begin
        for (int j = 0; j < vim_pkg::WIN_WORDS; j++) begin
            win_nxt[j] = (j + int'(take) < vim_pkg::WIN_WORDS) ? win_r[j + int'(take)] : '0;
            if (accept && j >= int'(rem) && j < int'(rem) + vim_pkg::FP_WORDS) begin
                win_nxt[j] = fetch_data[(j - int'(rem))*32 +: 32];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r <= 5'h00;
            for (int j = 0; j < vim_pkg::WIN_WORDS; j++) win_r[j] <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            for (int j = 0; j < vim_pkg::WIN_WORDS; j++) win_r[j] <= win_nxt[j];
        end
    end

    // route each issued word to its unit; first claim wins
    logic [7:0]   slot_vld;
    logic [255:0] slot_ins;
    logic         dup;
    logic [3:0]   fpc;
    always_comb begin
        slot_vld = '0;
        slot_ins = '0;
        dup      = 1'b0;
        fpc      = 4'h0;
        for (int i = 0; i < vim_pkg::FP_WORDS; i++) begin
            if (fire && i < int'(end_len)) begin
                if (slot_vld[win_r[i][3:1]]) begin
                    dup = 1'b1;
                end else begin
                    slot_vld[win_r[i][3:1]]           = 1'b1;
                    slot_ins[win_r[i][3:1]*32 +: 32] = win_r[i];
                end
            end
        end
        for (int u = 0; u < vim_pkg::UNITS; u++) begin
            if (slot_vld[u]) begin
                case (slot_ins[u*32+vim_pkg::OPC_LSB +: 6])
                    vim_pkg::OP_ADD_S, vim_pkg::OP_ADD_D,
                    vim_pkg::OP_SUB_S, vim_pkg::OP_SUB_D: fpc = fpc + 4'h1;
                    default: fpc = fpc;
                endcase
            end
        end
    end

    // units allowed per opcode class: mul on m, add/sub on l or s, load/store on d
    logic bad_unit;
    always_comb begin
        bad_unit = 1'b0;
        for (int u = 0; u < vim_pkg::UNITS; u++) begin
            if (slot_vld[u]) begin
                case (slot_ins[u*32+vim_pkg::OPC_LSB +: 6])
                    vim_pkg::OP_MUL_SD, vim_pkg::OP_MUL_SSD, vim_pkg::OP_MUL_DD:
                        bad_unit = bad_unit | (2'(u) != vim_pkg::U_M);
                    vim_pkg::OP_ADD_S, vim_pkg::OP_ADD_D, vim_pkg::OP_SUB_S, vim_pkg::OP_SUB_D:
                        bad_unit = bad_unit | (2'(u) == vim_pkg::U_M)
                                            | (2'(u) == vim_pkg::U_D);
                    vim_pkg::OP_LDW, vim_pkg::OP_STB, vim_pkg::OP_STH, vim_pkg::OP_STW:
                        bad_unit = bad_unit | (2'(u) != vim_pkg::U_D);
                    default: bad_unit = bad_unit;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            unit_vld      <= '0;
            unit_ins      <= '0;
            fp_addsub_cnt <= 4'h0;
            pkt_err       <= 1'b0;
        end else if (ce) begin
            unit_vld      <= slot_vld;
            unit_ins      <= slot_ins;
            fp_addsub_cnt <= fpc;
            pkt_err       <= overl | dup | bad_unit;
        end
    end

    // read addresses: ports 0..7 own sources, port 8 the cross operand for the far side
    logic [44:0] ra [2];
    logic [4:0]  xa [2];
    logic [1:0]  xerr;
    logic [1:0]  over;
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            xa[s]   = 5'h00;
            xerr[s] = 1'b0;
            ra[s]   = '0;
            for (int k = vim_pkg::SIDE_UNITS - 1; k >= 0; k--) begin
                if (unit_vld[s*4+k] && unit_ins[(s*4+k)*32+vim_pkg::XBIT_POS]) begin
                    xa[s] = unit_ins[(s*4+k)*32+vim_pkg::SRC2_LSB +: 5];
                end
            end
            for (int k = 0; k < vim_pkg::SIDE_UNITS; k++) begin
                ra[s][(2*k)*5 +: 5]   = unit_ins[(s*4+k)*32+vim_pkg::SRC1_LSB +: 5];
                ra[s][(2*k+1)*5 +: 5] = unit_ins[(s*4+k)*32+vim_pkg::SRC2_LSB +: 5];
                // a second, different cross register is a conflict; same one is shared
                if (unit_vld[s*4+k] && unit_ins[(s*4+k)*32+vim_pkg::XBIT_POS] &&
                    unit_ins[(s*4+k)*32+vim_pkg::SRC2_LSB +: 5] != xa[s]) begin
                    xerr[s] = 1'b1;
                end
            end
        end
        ra[0][44:40] = xa[1];
        ra[1][44:40] = xa[0];
    end

    // own-file read count per register; cross reads not counted
    logic [7:0] rv [2];
    always_comb begin
        int n;
        n    = 0;
        over = '0;
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 8; p++) begin
                rv[s][p] = unit_vld[s*4+p/2] &&
                           !((p % 2 == 1) && unit_ins[(s*4+p/2)*32+vim_pkg::XBIT_POS]);
            end
        end
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 8; p++) begin
                n = 0;
                for (int q = 0; q < 8; q++) begin
                    if (rv[s][p] && rv[s][q] && ra[s][p*5 +: 5] == ra[s][q*5 +: 5]) n++;
                end
                if (n > vim_pkg::RD_LIMIT) over[s] = 1'b1;
            end
        end
    end

    logic [287:0] rd [2];
    logic [7:0]   xsel_r;
    logic [7:0]   opv_r;
    logic [47:0]  opc_r;

    for (genvar s = 0; s < 2; s++) begin : g_side
        vim_regfile #(.NREG(vim_pkg::REGS), .DW(32), .NRD(9), .NWR(4)) u_rf (
            .sys_clk (sys_clk),
            .rst_n   (rst_n_r),
            .ce      (ce),
            .rd_addr (ra[s]),
            .rd_data (rd[s]),
            .wr_en   (wb_en[s*4 +: 4]),
            .wr_addr (wb_addr[s*20 +: 20]),
            .wr_data (wb_data[s*128 +: 128])
        );
    end

    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            xsel_r       <= '0;
            opv_r        <= '0;
            opc_r        <= '0;
            rd_limit_err <= 1'b0;
            xpath_err    <= 1'b0;
        end else if (ce) begin
            opv_r        <= unit_vld;
            rd_limit_err <= |over;
            xpath_err    <= |xerr;
            for (int u = 0; u < 8; u++) begin
                xsel_r[u]        <= unit_ins[u*32+vim_pkg::XBIT_POS];
                opc_r[u*6 +: 6]  <= unit_ins[u*32+vim_pkg::OPC_LSB +: 6];
            end
        end
    end

    // operand b takes the cross read of the far file when the cross bit is set
    assign op_vld = opv_r;
    for (genvar u = 0; u < 8; u++) begin : g_op
        assign op_a[u*32 +: 32] = rd[u/4][(u%4)*64 +: 32];
        assign op_b[u*32 +: 32] = xsel_r[u] ? rd[1-u/4][256 +: 32]
                                            : rd[u/4][(u%4)*64+32 +: 32];
    end

    // load-store units only: address from operand a, store data from operand b
    for (genvar s = 0; s < 2; s++) begin : g_mem
        wire [5:0]  dop = opc_r[(s*4+3)*6 +: 6];
        wire [31:0] adr = op_a[(s*4+3)*32 +: 32];
        wire [31:0] dat = op_b[(s*4+3)*32 +: 32];
        wire        isb = dop == vim_pkg::OP_STB;
        wire        ish = dop == vim_pkg::OP_STH;
        wire        isw = dop == vim_pkg::OP_STW;
        assign mem_req[s] = opv_r[s*4+3] && (isb || ish || isw || dop == vim_pkg::OP_LDW);
        assign mem_we[s]  = opv_r[s*4+3] && (isb || ish || isw);
        assign mem_be[s*4 +: 4] = isb ? (4'h1 << adr[1:0]) :
                                  ish ? (adr[1] ? 4'hC : 4'h3) : 4'hF;
        assign mem_addr[s*32 +: 32]  = adr;
        assign mem_wdata[s*32 +: 32] = isb ? {4{dat[7:0]}} : ish ? {2{dat[15:0]}} : dat;
    end

    // dma event registers; a set in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            dma_event_trigger_reg <= '0;
            dma_event_status_reg  <= '0;
        end else if (ce) begin
            if (evt_trig_we) dma_event_trigger_reg <= evt_trig_data;
            dma_event_status_reg <= (dma_event_status_reg & ~evt_stat_clr) | evt_stat_set;
        end
    end

    // interrupt map
    wire [10:0] sh  = {spi_int, i2c_int, realtime_tick_timer_ovf, realtime_tick_timer_int[3:1],
                       external_memory_if_nmi, dma_nmi} & shared_en;
    wire        dok = dma_evt_vld && dma_evt_int_en;
    wire [15:0] imap;
    assign imap[0]  = 1'b0;
    assign imap[1]  = |sh[1:0];
    assign imap[3:2] = 2'h0;
    assign imap[4]  = realtime_tick_timer_int[0];
    assign imap[5]  = |sh[6:2];
    assign imap[6]  = host_port_int;
    assign imap[7]  = dma_fifo_int;
    assign imap[8]  = dma_done_int;
    for (genvar l = 0; l < 5; l++) begin : g_dint
        assign imap[vim_pkg::DMA_INT_LO+l] = dok && dma_evt_code == vim_pkg::DCODE_LO + 3'(l);
    end
    assign imap[14] = |sh[10:7];
    assign imap[15] = dok && dma_evt_code == vim_pkg::DCODE_15;

    // line 0 is loaded high by the internal reset and cleared on the first cycle with the clock enable high
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cpu_int <= 16'h0001;
        end else if (ce) begin
            cpu_int <= imap;
        end
    end

    reserved_lines_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        cpu_int[3:2] == 2'h0) else $error("lines 2 and 3 active");
    timer0_line_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rst_n_r && ce && realtime_tick_timer_int[0] |=> cpu_int[4])
        else $error("timer 0 not on line 4");
    serial_share_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rst_n_r && ce && |({spi_int, i2c_int} & shared_en[10:7]) |=> cpu_int[14])
        else $error("serial interrupt lost");
    dma_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rst_n_r && ce && dok && dma_evt_code == 3'h2 |=> cpu_int[9] && !cpu_int[10])
        else $error("dma code 2 misrouted");
    dma_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ce && !dok |=> cpu_int[13:9] == 5'h00 && !cpu_int[15])
        else $error("dma interrupt without enable");
    status_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        rst_n_r && ce |=> (dma_event_status_reg & $past(evt_stat_set)) == $past(evt_stat_set))
        else $error("status set lost");
    issue_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ce && fire |=> unit_vld != 8'h00) else $error("packet not issued");
    no_fetch_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ce && !fire && !accept |=> cnt_r == $past(cnt_r)) else $error("window moved");
    read_limit_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        ce && |over |=> rd_limit_err) else $error("read limit not flagged");
    store_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n_r)
        mem_we[0] |-> mem_be[3:0] != 4'h0 && mem_req[0]) else $error("store without lanes");
endmodule

//--- vim_periph_model.sv
// peripheral, timer and dma source model driving the core's interrupt inputs
`timescale 1ns/1ps
module vim_periph_model (
    // clocking
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // requests from the bench
    input  wire logic [14:0] src,
    input  wire logic [4:0]  evt,
    // level sources
    output logic             dma_nmi,
    output logic             external_memory_if_nmi,
    output logic [3:0]       realtime_tick_timer_int,
    output logic [1:0]       realtime_tick_timer_ovf,
    output logic             host_port_int,
    output logic             dma_fifo_int,
    output logic             dma_done_int,
    output logic [1:0]       i2c_int,
    output logic [1:0]       spi_int,
    // dma event entry
    output logic             dma_evt_vld,
    output logic [2:0]       dma_evt_code,
    output logic             dma_evt_int_en
);
    logic [19:0] src_r;
    // sources change one cycle after the bench asks, like a real peripheral flop
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) src_r <= 20'h00000;
        else src_r <= {evt, src};
    end
    assign {spi_int, i2c_int, dma_done_int, dma_fifo_int} = src_r[14:9];
    assign {host_port_int, realtime_tick_timer_ovf, realtime_tick_timer_int,
            external_memory_if_nmi, dma_nmi} = src_r[8:0];
    // entry flag says whether the event was programmed to interrupt
    assign {dma_evt_vld, dma_evt_int_en, dma_evt_code} = src_r[19:15];
endmodule

//--- vim_pkg.sv
// shared constants for the vliw issue front end and interrupt map
package vim_pkg;
    // instruction field positions (one 32-bit slot)
    localparam int PBIT_POS   = 0;
    localparam int UNIT_LSB   = 1;
    localparam int XBIT_POS   = 4;
    localparam int SRC1_LSB   = 5;
    localparam int SRC2_LSB   = 10;
    localparam int OPC_LSB    = 20;
    // geometry
    localparam int INS_W      = 32;
    localparam int FP_WORDS   = 8;
    localparam int WIN_WORDS  = 16;
    localparam int UNITS      = 8;
    localparam int SIDE_UNITS = 4;
    localparam int REGS       = 32;
    localparam int RD_LIMIT   = 4;
    // unit slot within a side: l, s, m, d
    localparam logic [1:0] U_L = 2'h0;
    localparam logic [1:0] U_S = 2'h1;
    localparam logic [1:0] U_M = 2'h2;
    localparam logic [1:0] U_D = 2'h3;
    // opcodes
    localparam logic [5:0] OP_LDW     = 6'h01;
    localparam logic [5:0] OP_STB     = 6'h02;
    localparam logic [5:0] OP_STH     = 6'h03;
    localparam logic [5:0] OP_STW     = 6'h04;
    localparam logic [5:0] OP_MUL_SD  = 6'h10;
    localparam logic [5:0] OP_MUL_SSD = 6'h11;
    localparam logic [5:0] OP_MUL_DD  = 6'h12;
    localparam logic [5:0] OP_ADD_S   = 6'h18;
    localparam logic [5:0] OP_ADD_D   = 6'h19;
    localparam logic [5:0] OP_SUB_S   = 6'h1A;
    localparam logic [5:0] OP_SUB_D   = 6'h1B;
    // interrupt lines
    localparam int INT_LINES  = 16;
    localparam int DMA_INT_LO = 9;
    localparam logic [2:0] DCODE_LO   = 3'h2;
    localparam logic [2:0] DCODE_HI   = 3'h6;
    localparam logic [2:0] DCODE_15   = 3'h7;
endpackage

//--- vim_regfile.sv
// one datapath register file, registered read ports
`timescale 1ns/1ps
module vim_regfile #(
    parameter int NREG = 32,
    parameter int DW   = 32,
    parameter int NRD  = 9,
    parameter int NWR  = 4
) (
    // clocking
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // reads
    input  wire logic [NRD*5-1:0]          rd_addr,
    output logic      [NRD*DW-1:0]         rd_data,
    // writes, higher port wins on collision
    input  wire logic [NWR-1:0]            wr_en,
    input  wire logic [NWR*5-1:0]          wr_addr,
    input  wire logic [NWR*DW-1:0]         wr_data
);
    logic [DW-1:0] mem [NREG];

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            for (int w = 0; w < NWR; w++) begin
                if (wr_en[w]) begin
                    mem[wr_addr[w*5 +: 5]] <= wr_data[w*DW +: DW];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            for (int r = 0; r < NRD; r++) begin
                rd_data[r*DW +: DW] <= mem[rd_addr[r*5 +: 5]];
            end
        end
    end
endmodule
